// ### timer_pin_b_io_control.sv
// Functional notes
// [RQ1] compare mode when field top bit 0; low bits 00 disable the pin output
// [RQ2] compare, output enabled, bit 6 clear: pin starts low
// [RQ3] compare, output enabled, bit 6 set: pin starts high
// [RQ4] compare, low bits 01: pin driven low on each compare match
// [RQ5] compare, low bits 10: pin driven high on each compare match
// [RQ6] compare, low bits 11: pin toggles on each compare match
// [RQ7] channel 1, bits 7:6 = 10: capture triggered by its own pin b
// [RQ8] pin capture, bits 5:4 = 00: capture on rising pin edge
// [RQ9] pin capture, bits 5:4 = 01: capture on falling pin edge
// [RQ10] pin capture, bit 5 set: capture on both edges, bit 4 ignored
// [RQ11] channel 1, bits 7:6 = 11: capture on channel 0 register c event
// [RQ12] channel 2, bit 7 set: bit 6 ignored, pin b edge capture
// [RQ13] capture copies counter into register b in the detecting cycle
//
// The AXI4-Lite slave port and the register addresses were decided locally.
`timescale 1ns/1ps
module timer_pin_b_io_control import timer_pkg::*; #(
  parameter int unsigned CNT_W = 16
) (
  // clock and reset
  input  wire logic             mclk,
  input  wire logic             nrst,
  // axi4-lite write address
  input  wire logic [7:0]       awaddr,
  input  wire logic             awvalid,
  output logic                  awready,
  // axi4-lite write data
  input  wire logic [31:0]      wdata,
  input  wire logic [3:0]       wstrb,
  input  wire logic             wvalid,
  output logic                  wready,
  // axi4-lite write response
  output logic [1:0]            bresp,
  output logic                  bvalid,
  input  wire logic             bready,
  // axi4-lite read address
  input  wire logic [7:0]       araddr,
  input  wire logic             arvalid,
  output logic                  arready,
  // axi4-lite read data
  output logic [31:0]           rdata,
  output logic [1:0]            rresp,
  output logic                  rvalid,
  input  wire logic             rready,
  // counters and channel 0 event
  input  wire logic [CNT_W-1:0] ch1_count,
  input  wire logic [CNT_W-1:0] ch2_count,
  input  wire logic             ch0_regc_event,
  // channel 1 pin b
  input  wire logic             ch1_pin_b_in,
  output logic                  ch1_pin_b_out,
  output logic                  ch1_pin_b_oe,
  // channel 2 pin b
  input  wire logic             ch2_pin_b_in,
  output logic                  ch2_pin_b_out,
  output logic                  ch2_pin_b_oe
);

  ////////////////////////////////////////////////////////////////////////////
  // parameter check
  if (CNT_W < 1 || CNT_W > 32) begin : g_bad_width
    $error("CNT_W must lie in 1..32");
  end

  ////////////////////////////////////////////////////////////////////////////
  // declarations
  logic        awready_r;
  logic        wready_r;
  logic        bvalid_r;
  logic [1:0]  bresp_r;
  logic        arready_r;
  logic        rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0]  rresp_r;

  logic [7:0]  awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0]  wstrb_r;
  logic        aw_held_r;
  logic        w_held_r;

  logic        aw_take;
  logic        w_take;
  logic        ar_take;
  logic        do_wr;
  logic        aw_held_nxt;
  logic        w_held_nxt;
  logic        bvalid_nxt;
  logic        wr_mapped;

  logic [7:0]  ctrl1_r;
  logic [7:0]  ctrl2_r;
  logic        ctrl1_new_r;
  logic        ctrl2_new_r;
  logic        cap1_r;
  logic        cap2_r;
  logic        clr1;
  logic        clr2;

  logic [31:0] rd_data;
  logic        rd_mapped;
  logic [31:0] status;

  pin_b_if #(.CNT_W(CNT_W)) ch1_bus ();
  pin_b_if #(.CNT_W(CNT_W)) ch2_bus ();

  ////////////////////////////////////////////////////////////////////////////
  // write channel handshakes
  assign aw_take     = awvalid & awready_r;
  assign w_take      = wvalid & wready_r;
  assign do_wr       = aw_held_r & w_held_r & ~bvalid_r;
  assign aw_held_nxt = (aw_held_r & ~do_wr) | aw_take;
  assign w_held_nxt  = (w_held_r & ~do_wr) | w_take;
  assign bvalid_nxt  = do_wr | (bvalid_r & ~bready);

  assign wr_mapped = addr_hit(awaddr_r, OFS_CH1_CTRL) | addr_hit(awaddr_r, OFS_CH2_CTRL) |
                     addr_hit(awaddr_r, OFS_CH1_REGB) | addr_hit(awaddr_r, OFS_CH2_REGB) |
                     addr_hit(awaddr_r, OFS_STATUS);

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      aw_held_r <= 1'b0;
      w_held_r  <= 1'b0;
      awready_r <= 1'b0;
      wready_r  <= 1'b0;
    end else begin
      aw_held_r <= aw_held_nxt;
      w_held_r  <= w_held_nxt;
      awready_r <= ~aw_held_nxt & ~bvalid_nxt;
      wready_r  <= ~w_held_nxt & ~bvalid_nxt;
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      awaddr_r <= 8'h00;
      wdata_r  <= 32'h0000_0000;
      wstrb_r  <= 4'h0;
    end else begin
      if (aw_take) awaddr_r <= awaddr;
      if (w_take) begin
        wdata_r <= wdata;
        wstrb_r <= wstrb;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      bvalid_r <= 1'b0;
      bresp_r  <= RESP_OKAY;
    end else begin
      bvalid_r <= bvalid_nxt;
      if (do_wr) bresp_r <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // io control registers
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      ctrl1_r     <= CTRL_RST;
      ctrl2_r     <= CTRL_RST;
      ctrl1_new_r <= 1'b0;
      ctrl2_new_r <= 1'b0;
    end else begin
      ctrl1_new_r <= do_wr & addr_hit(awaddr_r, OFS_CH1_CTRL) & wstrb_r[0];
      ctrl2_new_r <= do_wr & addr_hit(awaddr_r, OFS_CH2_CTRL) & wstrb_r[0];
      if (do_wr && addr_hit(awaddr_r, OFS_CH1_CTRL) && wstrb_r[0]) begin
        ctrl1_r <= wdata_r[7:0];
      end
      if (do_wr && addr_hit(awaddr_r, OFS_CH2_CTRL) && wstrb_r[0]) begin
        ctrl2_r <= wdata_r[7:0];
      end
    end
  end

  assign ch1_bus.ctrl     = ctrl1_r;
  assign ch2_bus.ctrl     = ctrl2_r;
  assign ch1_bus.ctrl_new = ctrl1_new_r;
  assign ch2_bus.ctrl_new = ctrl2_new_r;

  // register b writes, merged by byte strobe
  assign ch1_bus.regb_wr    = do_wr & addr_hit(awaddr_r, OFS_CH1_REGB);
  assign ch2_bus.regb_wr    = do_wr & addr_hit(awaddr_r, OFS_CH2_REGB);
  assign ch1_bus.regb_wdata = CNT_W'(merge_strb(32'(ch1_bus.regb), wdata_r, wstrb_r));
  assign ch2_bus.regb_wdata = CNT_W'(merge_strb(32'(ch2_bus.regb), wdata_r, wstrb_r));

  ////////////////////////////////////////////////////////////////////////////
  // capture flags, write one to clear, a new capture wins
  assign clr1 = do_wr & addr_hit(awaddr_r, OFS_STATUS) & wstrb_r[0] & wdata_r[ST_CAP1];
  assign clr2 = do_wr & addr_hit(awaddr_r, OFS_STATUS) & wstrb_r[0] & wdata_r[ST_CAP2];

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      cap1_r <= 1'b0;
      cap2_r <= 1'b0;
    end else begin
      cap1_r <= ch1_bus.cap_pulse | (cap1_r & ~clr1);
      cap2_r <= ch2_bus.cap_pulse | (cap2_r & ~clr2);
    end
  end

  always_comb begin
    status          = 32'h0000_0000;
    status[ST_CAP1] = cap1_r;
    status[ST_CAP2] = cap2_r;
    status[ST_LVL1] = ch1_bus.pin_lvl;
    status[ST_LVL2] = ch2_bus.pin_lvl;
    status[ST_OE1]  = ch1_bus.pin_oe;
    status[ST_OE2]  = ch2_bus.pin_oe;
  end

  ////////////////////////////////////////////////////////////////////////////
  // read path
  assign ar_take = arvalid & arready_r;

  always_comb begin
    rd_data   = 32'h0000_0000;
    rd_mapped = 1'b1;
    if (addr_hit(araddr, OFS_CH1_CTRL)) begin
      rd_data[7:0] = ctrl1_r;
    end else if (addr_hit(araddr, OFS_CH2_CTRL)) begin
      rd_data[7:0] = ctrl2_r;
    end else if (addr_hit(araddr, OFS_CH1_REGB)) begin
      rd_data = 32'(ch1_bus.regb);
    end else if (addr_hit(araddr, OFS_CH2_REGB)) begin
      rd_data = 32'(ch2_bus.regb);
    end else if (addr_hit(araddr, OFS_STATUS)) begin
      rd_data = status;
    end else begin
      rd_mapped = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b0;
      rdata_r   <= 32'h0000_0000;
      rresp_r   <= RESP_OKAY;
    end else if (ar_take) begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b1;
      rdata_r   <= rd_data;
      rresp_r   <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_r && rready) begin
      rvalid_r  <= 1'b0;
      arready_r <= 1'b1;
    end else if (!rvalid_r) begin
      arready_r <= 1'b1;
    end
  end

  assign awready = awready_r;
  assign wready  = wready_r;
  assign bvalid  = bvalid_r;
  assign bresp   = bresp_r;
  assign arready = arready_r;
  assign rvalid  = rvalid_r;
  assign rdata   = rdata_r;
  assign rresp   = rresp_r;

  ////////////////////////////////////////////////////////////////////////////
  // channels
  pin_b_channel #(.CNT_W(CNT_W), .IS_CH1(1'b1)) u_ch1 (
    .mclk           (mclk),
    .nrst           (nrst),
    .count          (ch1_count),
    .ch0_regc_event (ch0_regc_event),
    .pin_raw        (ch1_pin_b_in),
    .bus            (ch1_bus.chan)
  );

  pin_b_channel #(.CNT_W(CNT_W), .IS_CH1(1'b0)) u_ch2 (
    .mclk           (mclk),
    .nrst           (nrst),
    .count          (ch2_count),
    .ch0_regc_event (ch0_regc_event),
    .pin_raw        (ch2_pin_b_in),
    .bus            (ch2_bus.chan)
  );

  assign ch1_pin_b_out = ch1_bus.pin_lvl;
  assign ch1_pin_b_oe  = ch1_bus.pin_oe;
  assign ch2_pin_b_out = ch2_bus.pin_lvl;
  assign ch2_pin_b_oe  = ch2_bus.pin_oe;

  ////////////////////////////////////////////////////////////////////////////
  // compare-side checks on channel 1
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  chk_out_disabled: assert property ( // [RQ1]
    (!ctrl1_r[FLD_MODE] && ctrl1_r[5:4] == ACT_NONE) [*2] |-> !ch1_pin_b_oe)
    else $error("disabled compare output still enabled");
  chk_init_low: assert property ( // [RQ2]
    ctrl1_new_r && !ctrl1_r[FLD_MODE] && ctrl1_r[5:4] != ACT_NONE && !ctrl1_r[FLD_SRC]
    |=> ch1_pin_b_oe && !ch1_pin_b_out)
    else $error("initial low level not driven");
  chk_init_high: assert property ( // [RQ3]
    ctrl1_new_r && !ctrl1_r[FLD_MODE] && ctrl1_r[5:4] != ACT_NONE && ctrl1_r[FLD_SRC]
    |=> ch1_pin_b_oe && ch1_pin_b_out)
    else $error("initial high level not driven");
  chk_match_low: assert property ( // [RQ4]
    !ctrl1_new_r && !ctrl1_r[FLD_MODE] && ctrl1_r[5:4] == ACT_LOW &&
    ch1_count == ch1_bus.regb && ch1_count != $past(ch1_count) |=> !ch1_pin_b_out)
    else $error("match did not drive pin low");
  chk_match_high: assert property ( // [RQ5]
    !ctrl1_new_r && !ctrl1_r[FLD_MODE] && ctrl1_r[5:4] == ACT_HIGH &&
    ch1_count == ch1_bus.regb && ch1_count != $past(ch1_count) |=> ch1_pin_b_out)
    else $error("match did not drive pin high");
  chk_match_toggle: assert property ( // [RQ6]
    !ctrl1_new_r && !ctrl1_r[FLD_MODE] && ctrl1_r[5:4] == ACT_TOGGLE &&
    ch1_count == ch1_bus.regb && ch1_count != $past(ch1_count)
    |=> ch1_pin_b_out != $past(ch1_pin_b_out))
    else $error("match did not toggle pin");

  ////////////////////////////////////////////////////////////////////////////
  // compare-side checks on channel 2
  chk_out_off_ch2: assert property ( // [RQ1]
    (!ctrl2_r[FLD_MODE] && ctrl2_r[5:4] == ACT_NONE) [*2] |-> !ch2_pin_b_oe)
    else $error("channel 2 disabled output still enabled");
  chk_init_low_ch2: assert property ( // [RQ2]
    ctrl2_new_r && !ctrl2_r[FLD_MODE] && ctrl2_r[5:4] != ACT_NONE && !ctrl2_r[FLD_SRC]
    |=> ch2_pin_b_oe && !ch2_pin_b_out)
    else $error("channel 2 initial low level not driven");
  chk_init_high_ch2: assert property ( // [RQ3]
    ctrl2_new_r && !ctrl2_r[FLD_MODE] && ctrl2_r[5:4] != ACT_NONE && ctrl2_r[FLD_SRC]
    |=> ch2_pin_b_oe && ch2_pin_b_out)
    else $error("channel 2 initial high level not driven");
  chk_match_low_ch2: assert property ( // [RQ4]
    !ctrl2_new_r && !ctrl2_r[FLD_MODE] && ctrl2_r[5:4] == ACT_LOW &&
    ch2_count == ch2_bus.regb && ch2_count != $past(ch2_count) |=> !ch2_pin_b_out)
    else $error("channel 2 match did not drive pin low");
  chk_match_high_ch2: assert property ( // [RQ5]
    !ctrl2_new_r && !ctrl2_r[FLD_MODE] && ctrl2_r[5:4] == ACT_HIGH &&
    ch2_count == ch2_bus.regb && ch2_count != $past(ch2_count) |=> ch2_pin_b_out)
    else $error("channel 2 match did not drive pin high");
  chk_toggle_ch2: assert property ( // [RQ6]
    !ctrl2_new_r && !ctrl2_r[FLD_MODE] && ctrl2_r[5:4] == ACT_TOGGLE &&
    ch2_count == ch2_bus.regb && ch2_count != $past(ch2_count)
    |=> ch2_pin_b_out != $past(ch2_pin_b_out))
    else $error("channel 2 match did not toggle pin");

endmodule // timer_pin_b_io_control

// ### timer_pkg.sv
package timer_pkg;

  // register byte offsets
  localparam logic [7:0] OFS_CH1_CTRL = 8'h00;
  localparam logic [7:0] OFS_CH2_CTRL = 8'h04;
  localparam logic [7:0] OFS_CH1_REGB = 8'h08;
  localparam logic [7:0] OFS_CH2_REGB = 8'h0c;
  localparam logic [7:0] OFS_STATUS   = 8'h10;

  // reset values
  localparam logic [7:0] CTRL_RST = 8'h00;

  // pin-b field positions in the io control registers
  localparam int unsigned FLD_MODE = 7;
  localparam int unsigned FLD_SRC  = 6;
  localparam int unsigned FLD_EDGE = 5;
  localparam int unsigned FLD_FALL = 4;

  // status register bit positions
  localparam int unsigned ST_CAP1 = 0;
  localparam int unsigned ST_CAP2 = 1;
  localparam int unsigned ST_LVL1 = 4;
  localparam int unsigned ST_LVL2 = 5;
  localparam int unsigned ST_OE1  = 8;
  localparam int unsigned ST_OE2  = 9;

  // compare actions on the low two field bits
  localparam logic [1:0] ACT_NONE   = 2'h0;
  localparam logic [1:0] ACT_LOW    = 2'h1;
  localparam logic [1:0] ACT_HIGH   = 2'h2;
  localparam logic [1:0] ACT_TOGGLE = 2'h3;

  // bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    MODE_OFF     = 2'h0,
    MODE_CMP     = 2'h1,
    MODE_CAP_PIN = 2'h3,
    MODE_CAP_EVT = 2'h2
  } pin_mode_t;

  // field is bits 7:4 of an io control register
  function automatic pin_mode_t decode_mode(input logic [3:0] fld, input logic is_ch1);
    if (!fld[3]) begin
      return (fld[1:0] == ACT_NONE) ? MODE_OFF : MODE_CMP;
    end
    return (is_ch1 && fld[2]) ? MODE_CAP_EVT : MODE_CAP_PIN;
  endfunction

  function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] ofs);
    return addr[7:2] == ofs[7:2];
  endfunction

  function automatic logic [31:0] merge_strb(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) res[8*i +: 8] = new_v[8*i +: 8];
    end
    return res;
  endfunction

endpackage

// ### pin_b_if.sv
`timescale 1ns/1ps
interface pin_b_if #(parameter int unsigned CNT_W = 16);
  logic [7:0]       ctrl;
  logic             ctrl_new;
  logic             regb_wr;
  logic [CNT_W-1:0] regb_wdata;
  logic [CNT_W-1:0] regb;
  logic             cap_pulse;
  logic             pin_lvl;
  logic             pin_oe;

  modport ctl  (output ctrl, ctrl_new, regb_wr, regb_wdata,
                input  regb, cap_pulse, pin_lvl, pin_oe);
  modport chan (input  ctrl, ctrl_new, regb_wr, regb_wdata,
                output regb, cap_pulse, pin_lvl, pin_oe);
endinterface

// ### pin_edge_detect.sv
`timescale 1ns/1ps
module pin_edge_detect (
  // clock and reset
  input  wire logic mclk,
  input  wire logic nrst,
  // pin and edges
  input  wire logic pin_raw,
  output logic      rise,
  output logic      fall
);

  logic meta_r;
  logic sync_r;
  logic prev_r;

  // two-stage synchroniser, then edge history
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      prev_r <= 1'b0;
    end else begin
      meta_r <= pin_raw;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  assign rise = sync_r & ~prev_r;
  assign fall = ~sync_r & prev_r;

endmodule // pin_edge_detect

// ### pin_b_channel.sv
`timescale 1ns/1ps
module pin_b_channel import timer_pkg::*; #(
  parameter int unsigned CNT_W  = 16,
  parameter bit          IS_CH1 = 1'b1
) (
  // clock and reset
  input  wire logic             mclk,
  input  wire logic             nrst,
  // counter and channel 0 event
  input  wire logic [CNT_W-1:0] count,
  input  wire logic             ch0_regc_event,
  // pin input
  input  wire logic             pin_raw,
  // register side
  pin_b_if.chan                 bus
);

  logic [3:0]       fld;
  pin_mode_t        mode;
  logic             rise;
  logic             fall;
  logic             pin_evt;
  logic             cmp_match;
  logic [CNT_W-1:0] count_q_r;

  assign fld  = bus.ctrl[FLD_MODE:FLD_FALL];
  assign mode = decode_mode(fld, IS_CH1);

  pin_edge_detect u_edge (
    .mclk    (mclk),
    .nrst    (nrst),
    .pin_raw (pin_raw),
    .rise    (rise),
    .fall    (fall)
  );

  always_ff @(posedge mclk) begin
    if (!nrst) count_q_r <= '0;
    else       count_q_r <= count;
  end

  // match when the counter arrives at register b
  assign cmp_match = (mode == MODE_CMP) && (count == bus.regb) && (count != count_q_r);
  assign pin_evt   = fld[1] ? (rise | fall) : (fld[0] ? fall : rise); // [RQ8] [RQ9] [RQ10]
  assign bus.cap_pulse = ((mode == MODE_CAP_PIN) && pin_evt) ||     // [RQ7] [RQ12]
                         ((mode == MODE_CAP_EVT) && ch0_regc_event); // [RQ11]

  always_ff @(posedge mclk) begin
    if (!nrst)               bus.regb <= '0;
    else if (bus.cap_pulse)  bus.regb <= count; // [RQ13]
    else if (bus.regb_wr)    bus.regb <= bus.regb_wdata;
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      bus.pin_lvl <= 1'b0;
      bus.pin_oe  <= 1'b0;
    end else if (mode != MODE_CMP) begin
      bus.pin_oe  <= 1'b0; // [RQ1]
    end else if (bus.ctrl_new) begin
      bus.pin_lvl <= fld[2]; // [RQ2] [RQ3]
      bus.pin_oe  <= 1'b1;
    end else if (cmp_match) begin
      case (fld[1:0])
        ACT_LOW:    bus.pin_lvl <= 1'b0;         // [RQ4]
        ACT_HIGH:   bus.pin_lvl <= 1'b1;         // [RQ5]
        ACT_TOGGLE: bus.pin_lvl <= ~bus.pin_lvl; // [RQ6]
        default:    bus.pin_lvl <= bus.pin_lvl;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  chk_cap_rise_only: assert property ( // [RQ8]
    (mode == MODE_CAP_PIN) && (fld[1:0] == 2'h0) |-> bus.cap_pulse == rise)
    else $error("rising-edge capture mismatch");
  chk_cap_fall_only: assert property ( // [RQ9]
    (mode == MODE_CAP_PIN) && (fld[1:0] == 2'h1) |-> bus.cap_pulse == fall)
    else $error("falling-edge capture mismatch");
  chk_cap_both_edges: assert property ( // [RQ10]
    (mode == MODE_CAP_PIN) && fld[1] |-> bus.cap_pulse == (rise || fall))
    else $error("both-edge capture mismatch");
  chk_pin_source: assert property ( // [RQ7]
    fld[3] && !fld[2] && bus.cap_pulse |-> rise || fall)
    else $error("pin capture without pin edge");
  chk_regc_source: assert property ( // [RQ11]
    IS_CH1 && (fld[3:2] == 2'h3) |-> bus.cap_pulse == ch0_regc_event)
    else $error("channel 0 event capture mismatch");
  chk_ch2_pin_only: assert property ( // [RQ12]
    !IS_CH1 && fld[3] |-> bus.cap_pulse == (fld[1] ? (rise || fall) : (fld[0] ? fall : rise)))
    else $error("channel 2 capture not from pin");
  chk_capture_copy: assert property ( // [RQ13]
    bus.cap_pulse |=> bus.regb == $past(count))
    else $error("capture did not copy counter");

endmodule // pin_b_channel

// ### pin_partner.sv
`timescale 1ns/1ps
module pin_partner #(
  parameter int unsigned CNT_W = 16
) (
  // clock
  input  wire logic             mclk,
  // timer side of the pins
  input  wire logic [1:0]       pin_out,
  input  wire logic [1:0]       pin_oe,
  // board side of the pins
  output logic [1:0]            pin_in,
  // counter and channel 0 event
  output logic [CNT_W-1:0]      count,
  output logic                  evt
);
  logic [1:0] ext_lvl;
  logic [1:0] ext_oe;
  logic       run;

  ////////////////////////////////////////////////////////////
  // timer wins, then board driver, else pull-up
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ((ext_oe & ext_lvl) | ~ext_oe));

  initial begin
    ext_lvl = 2'b00;
    ext_oe  = 2'b11;
    run     = 1'b0;
    count   = '0;
    evt     = 1'b0;
  end

  always @(posedge mclk) begin
    if (run) count <= count + 1'b1;
  end

  ////////////////////////////////////////////////////////////
  task automatic set_run(input logic v);
    @(posedge mclk);
    run <= v;
  endtask

  task automatic load(input logic [CNT_W-1:0] v);
    @(posedge mclk);
    count <= v;
  endtask

  task automatic drive(input int c, input logic v);
    @(posedge mclk);
    ext_lvl[c] <= v;
    ext_oe[c]  <= 1'b1;
  endtask

  task automatic release_pins();
    @(posedge mclk);
    ext_oe <= 2'b00;
  endtask

  task automatic pulse();
    @(posedge mclk);
    evt <= 1'b1;
    @(posedge mclk);
    evt <= 1'b0;
  endtask
endmodule // pin_partner

// ### timer_pin_b_io_control_tb_top.sv
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin err_total++; \
  $display("[FAIL] %s exp %0h got %0h", nm, ex, got); end end
module timer_pin_b_io_control_tb_top import timer_pkg::*;;
  logic        mclk;
  logic        nrst;
  logic [7:0]  awaddr, araddr;
  logic        awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic [15:0] count;
  logic        evt;
  logic [1:0]  pin_in, pin_out, pin_oe;
  int          err_total, compares;

  ////////////////////////////////////////////////////////////
  timer_pin_b_io_control i_dut (
    .mclk, .nrst, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
    .rvalid, .rready, .ch1_count(count), .ch2_count(count), .ch0_regc_event(evt),
    .ch1_pin_b_in(pin_in[0]), .ch1_pin_b_out(pin_out[0]), .ch1_pin_b_oe(pin_oe[0]),
    .ch2_pin_b_in(pin_in[1]), .ch2_pin_b_out(pin_out[1]), .ch2_pin_b_oe(pin_oe[1])
  );

  pin_partner i_pins (.mclk, .pin_out, .pin_oe, .pin_in, .count, .evt);

  ////////////////////////////////////////////////////////////
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] rs);
    @(posedge mclk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge mclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    rs = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
    @(posedge mclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge mclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d  = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask

  task automatic cmp_case(input int c, input logic [3:0] f);
    logic [31:0] d;
    logic [1:0]  rs;
    logic [15:0] tgt;
    logic        ex;
    tgt = count + 16'd40;
    wr(OFS_CH1_REGB + 8'(4*c), {16'h0, tgt}, rs);
    wr(OFS_CH1_CTRL + 8'(4*c), {24'h0, f, 4'h0}, rs);
    rd(OFS_CH1_CTRL + 8'(4*c), d, rs);
    `CHK("ctrl readback", {f, 4'h0}, d[7:0])
    repeat (2) @(posedge mclk);
    `CHK("initial oe", f[1:0] != 2'b00, pin_oe[c])
    if (f[1:0] != 2'b00) `CHK("initial level", f[2], pin_out[c])
    rd(OFS_STATUS, d, rs);
    `CHK("status oe", f[1:0] != 2'b00, d[ST_OE1 + c])
    if (f[1:0] != 2'b00) `CHK("status level", f[2], d[ST_LVL1 + c])
    while (count !== tgt) @(posedge mclk);
    repeat (3) @(posedge mclk);
    ex = (f[1:0] == 2'b01) ? 1'b0 : (f[1:0] == 2'b10) ? 1'b1 : ~f[2];
    `CHK("match oe", f[1:0] != 2'b00, pin_oe[c])
    if (f[1:0] != 2'b00) `CHK("match level", ex, pin_out[c])
  endtask

  task automatic cap_case(input int c, input logic [3:0] f, input int e);
    logic [31:0] d;
    logic [1:0]  rs;
    logic [15:0] v;
    logic        ex;
    v  = 16'h1000 + 16'(e) + {8'h0, f, 4'h0} + 16'(c << 8);
    ex = (e == 2) ? (c == 0 && f[2]) : (c == 0 && f[2]) ? 1'b0 : f[1] | (f[0] ^ (e == 0));
    wr(OFS_CH1_REGB + 8'(4*c), 32'h0, rs);
    wr(OFS_STATUS, 32'h3, rs);
    i_pins.load(v);
    if (e == 2) i_pins.pulse();
    else i_pins.drive(c, e == 0);
    repeat (8) @(posedge mclk);
    rd(OFS_STATUS, d, rs);
    `CHK("capture flag", ex, d[ST_CAP1 + c])
    rd(OFS_CH1_REGB + 8'(4*c), d, rs);
    `CHK("capture value", ex ? v : 16'h0, d[15:0])
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  initial begin
    repeat (20000) @(posedge mclk);
    err_total++;
    end_sim();
  end

  initial begin
    logic [31:0] d;
    logic [1:0]  rs;
    nrst    = 1'b0;
    awaddr  = 8'h00;
    araddr  = 8'h00;
    awvalid = 1'b0;
    wvalid  = 1'b0;
    bready  = 1'b0;
    arvalid = 1'b0;
    rready  = 1'b0;
    wdata   = 32'h0;
    wstrb   = 4'hf;
    repeat (5) @(posedge mclk);
    nrst <= 1'b1;
    // reset state and decode
    rd(OFS_CH1_CTRL, d, rs);
    `CHK("reset ctrl", 8'h00, d[7:0])
    `CHK("reset oe", 2'b00, pin_oe)
    wr(8'h14, 32'h5a, rs);
    `CHK("unmapped write", RESP_SLVERR, rs)
    rd(8'h14, d, rs);
    `CHK("unmapped read", RESP_SLVERR, rs)
    $display("test registers done");
    // compare modes, both channels
    i_pins.release_pins();
    i_pins.set_run(1'b1);
    for (int c = 0; c < 2; c++) begin
      for (int f = 0; f < 8; f++) cmp_case(c, 4'(f));
    end
    $display("test compare done");
    // capture modes, counter frozen
    i_pins.set_run(1'b0);
    wr(OFS_CH1_CTRL, 32'h0, rs);
    wr(OFS_CH2_CTRL, 32'h0, rs);
    i_pins.drive(0, 1'b0);
    i_pins.drive(1, 1'b0);
    repeat (6) @(posedge mclk);
    for (int c = 0; c < 2; c++) begin
      for (int f = 8; f < 16; f++) begin
        wr(OFS_CH1_CTRL + 8'(4*c), {24'h0, 4'(f), 4'h0}, rs);
        for (int e = 0; e < 3; e++) cap_case(c, 4'(f), e);
      end
    end
    $display("test capture done");
    end_sim();
  end
endmodule // timer_pin_b_io_control_tb_top
